// ==== rtl/edsc_top.sv ====
// Purpose: Sleep and wake sequencer of a mesh end device, APB registers
// Assumes: Pins and stack strobes synchronous to pclk
// Notes: Stack events are one-cycle pulses, busy flags are levels
// What this block does
// - Mode zero never sleeps, acts as router
// - Leaving mode zero triggers leave and rejoin
// - Awake indicator low asleep, high awake
// - CTS high asleep, low awake unless flow control holds it high
// - Mode one: sleep follows request pin level
// - Pin sleep waits for transfers to finish
// - Sleep deferred until join attempt finishes
// - Serial activity ignored while asleep, radio taken only in silent polls
// - Pin low wakes device, CTS low ready
// - Unjoined device scans for network on waking
// - Joined device polls on wake, every 100ms
// - Modes four, five cyclic; five wakes on fall
// - Received data restarts inactivity timer
// - Options zero: period times multiplier, max 28s
// - Poll each period, indicate every multiplier-th
// - Radio data in silent poll raises indicator
// - Options four sleeps whole product unbroken
// - Button press keeps device awake 30 seconds
//
// Chosen here: the placing of the registers and register access over APB.
module edsc_top
    import edsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_request_pin,
    input wire logic commission_button,
    input wire logic joined,
    input wire logic join_busy,
    input wire logic txrx_busy,
    input wire logic serial_rx_evt,
    input wire logic radio_rx_evt,
    input wire logic uart_rx_full,
    output logic awake_indicator,
    output logic cts_n,
    output logic routing_mode,
    output logic sleeping,
    output logic serial_rx_accept,
    output logic radio_rx_accept,
    output logic poll_req,
    output logic scan_start,
    output logic leave_rejoin
);
    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

    logic [2:0] sleep_mode_select;
    logic [2:0] sleep_options;
    logic [2:0] flow_pin_function;
    logic [11:0] poll_period;
    logic [15:0] inactivity_time;
    logic [15:0] wake_indicate_multiplier;

    edsc_state_e state;
    edsc_state_e next_state;
    logic [17:0] div_cnt;
    logic tick;
    logic pin_q;
    logic pin_fall;
    logic cyclic;
    logic awake_st;
    logic rx_any;
    logic [15:0] inact_cnt;
    logic [11:0] btn_cnt;
    logic [11:0] slp_cnt;
    logic [15:0] wake_cnt;
    logic [3:0] poll_cnt;
    logic period_end;
    logic wake_last;
    logic waking;
    logic idle_ok;
    logic [11:0] poll_eff;
    logic [15:0] mult_eff;
    logic [11:0] next_poll_wr;
    logic addr_ok;
    logic wr_en;
    logic setup;
    logic [31:0] rd_mux;

    // APB slave, zero wait states
    assign pready = 1'b1;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign pslverr = psel & penable & ~addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: begin
                rd_mux[CTRL_SM_LSB +: 3] = sleep_mode_select;
                rd_mux[CTRL_SO_LSB +: 3] = sleep_options;
                rd_mux[CTRL_FP_LSB +: 3] = flow_pin_function;
            end
            ADDR_POLL: rd_mux[11:0] = poll_period;
            ADDR_INACT: rd_mux[15:0] = inactivity_time;
            ADDR_MULT: rd_mux[15:0] = wake_indicate_multiplier;
            ADDR_STAT: begin
                rd_mux[STAT_STATE_LSB +: 4] = state;
                rd_mux[STAT_AWAKE_BIT] = awake_indicator;
                rd_mux[STAT_JOINED_BIT] = joined;
                rd_mux[STAT_ROUTE_BIT] = routing_mode;
                rd_mux[STAT_WCNT_LSB +: 16] = wake_cnt;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so it is stable at pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Clamp because the parent cannot hold data longer than that
    always_comb begin
        next_poll_wr = pwdata[11:0];
        if (pwdata[11:0] > POLL_MAX) begin
            next_poll_wr = POLL_MAX;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_mode_select <= SM_OFF;
            sleep_options <= SO_NONE;
            flow_pin_function <= 3'h0;
            poll_period <= POLL_RST;
            inactivity_time <= INACT_RST;
            wake_indicate_multiplier <= MULT_RST;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CTRL: begin
                    sleep_mode_select <= pwdata[CTRL_SM_LSB +: 3];
                    sleep_options <= pwdata[CTRL_SO_LSB +: 3];
                    flow_pin_function <= pwdata[CTRL_FP_LSB +: 3];
                end
                ADDR_POLL: poll_period <= next_poll_wr;
                ADDR_INACT: inactivity_time <= pwdata[15:0];
                ADDR_MULT: wake_indicate_multiplier <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Leaving router mode: drop out of the network and rejoin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leave_rejoin <= 1'b0;
        end else begin
            leave_rejoin <= wr_en && paddr == ADDR_CTRL &&
                sleep_mode_select == SM_OFF &&
                pwdata[CTRL_SM_LSB +: 3] != SM_OFF;
        end
    end

    // Timer base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 18'h00000;
        end else if (div_cnt == TICK_LAST) begin
            div_cnt <= 18'h00000;
        end else begin
            div_cnt <= div_cnt + 18'h00001;
        end
    end
    assign tick = div_cnt == TICK_LAST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= sleep_request_pin;
        end
    end
    assign pin_fall = pin_q & ~sleep_request_pin;

    assign cyclic = sleep_mode_select == SM_CYC ||
        sleep_mode_select == SM_CYC_PIN;
    assign awake_st = state == ST_AWAKE || state == ST_PEND;
    // Serial is shut out in silent polls, only the radio is listening
    assign serial_rx_accept = serial_rx_evt & awake_st;
    assign radio_rx_accept = radio_rx_evt &
        (awake_st | state == ST_SILENT);
    assign rx_any = serial_rx_accept | radio_rx_accept;
    assign idle_ok = ~txrx_busy & ~join_busy;
    assign poll_eff = poll_period == 12'h000 ? 12'h001 : poll_period;
    assign mult_eff = wake_indicate_multiplier == 16'h0000 ?
        16'h0001 : wake_indicate_multiplier;
    assign period_end = state == ST_ASLEEP && cyclic && tick &&
        slp_cnt == 12'h000;
    assign wake_last = (wake_cnt + 16'h0001) >= mult_eff;

    always_comb begin
        next_state = state;
        case (state)
            ST_AWAKE: begin
                if (commission_button || btn_cnt != 12'h000) begin
                    next_state = ST_AWAKE;
                end else if (sleep_mode_select == SM_PIN &&
                        sleep_request_pin) begin
                    next_state = ST_PEND;
                end else if (cyclic && inact_cnt == 16'h0000) begin
                    next_state = ST_PEND;
                end
            end
            ST_PEND: begin
                if (sleep_mode_select == SM_OFF) begin
                    next_state = ST_AWAKE;
                end else if (sleep_mode_select == SM_PIN &&
                        !sleep_request_pin) begin
                    next_state = ST_AWAKE;
                end else if (commission_button || btn_cnt != 12'h000) begin
                    next_state = ST_AWAKE;
                end else if (cyclic && rx_any) begin
                    next_state = ST_AWAKE;
                end else if (idle_ok) begin
                    next_state = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                if (sleep_mode_select == SM_OFF || commission_button) begin
                    next_state = ST_AWAKE;
                end else if (sleep_mode_select == SM_PIN) begin
                    if (!sleep_request_pin) begin
                        next_state = ST_AWAKE;
                    end
                end else if (!cyclic) begin
                    next_state = ST_AWAKE;
                end else if (sleep_mode_select == SM_CYC_PIN && pin_fall) begin
                    next_state = ST_AWAKE;
                end else if (period_end) begin
                    if (wake_last) begin
                        next_state = ST_AWAKE;
                    end else if (sleep_options != SO_LONG) begin
                        next_state = ST_SILENT;
                    end
                end
            end
            ST_SILENT: begin
                if (radio_rx_accept || commission_button || !cyclic) begin
                    next_state = ST_AWAKE;
                end else if (sleep_mode_select == SM_CYC_PIN && pin_fall) begin
                    next_state = ST_AWAKE;
                end else if (tick && idle_ok) begin
                    next_state = ST_ASLEEP;
                end
            end
            default: next_state = ST_AWAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    assign waking = next_state == ST_AWAKE &&
        (state == ST_ASLEEP || state == ST_SILENT);

    // Inactivity timer, restarted on wake and by every accepted reception in cyclic modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inact_cnt <= 16'h0000;
        end else if (waking || (rx_any && cyclic)) begin
            inact_cnt <= inactivity_time;
        end else if (tick && inact_cnt != 16'h0000) begin
            inact_cnt <= inact_cnt - 16'h0001;
        end
    end

    // Commissioning hold-awake window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_cnt <= 12'h000;
        end else if (commission_button) begin
            btn_cnt <= BUTTON_TICKS;
        end else if (tick && btn_cnt != 12'h000) begin
            btn_cnt <= btn_cnt - 12'h001;
        end
    end

    // Sleep period timer, one poll period per load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slp_cnt <= 12'h000;
        end else if ((next_state == ST_ASLEEP && state == ST_PEND) ||
                period_end) begin
            slp_cnt <= poll_eff - 12'h001;
        end else if ((state == ST_ASLEEP || state == ST_SILENT) && tick &&
                slp_cnt != 12'h000) begin
            // Silent poll time counts toward the period, no drift per poll
            slp_cnt <= slp_cnt - 12'h001;
        end
    end

    // Counts elapsed periods toward the multiplier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt <= 16'h0000;
        end else if (next_state == ST_AWAKE) begin
            wake_cnt <= 16'h0000;
        end else if (period_end) begin
            wake_cnt <= wake_cnt + 16'h0001;
        end
    end

    // Poll interval while awake as a joined end device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_cnt <= 4'h0;
        end else if (waking || !awake_st) begin
            poll_cnt <= POLL_TICKS - 4'h1;
        end else if (tick) begin
            if (poll_cnt == 4'h0) begin
                poll_cnt <= POLL_TICKS - 4'h1;
            end else begin
                poll_cnt <= poll_cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_req <= 1'b0;
        end else if (!joined || sleep_mode_select == SM_OFF) begin
            poll_req <= 1'b0;
        end else begin
            poll_req <= waking ||
                (next_state == ST_SILENT && state != ST_SILENT) ||
                (awake_st && tick && poll_cnt == 4'h0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_start <= 1'b0;
        end else begin
            scan_start <= waking && !joined;
        end
    end

    // Indicators; a silent poll keeps them in the sleep state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake_indicator <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            awake_indicator <= next_state == ST_AWAKE ||
                next_state == ST_PEND;
            sleeping <= next_state == ST_ASLEEP ||
                next_state == ST_SILENT;
        end
    end

    // Flow control can only add a hold, never release CTS while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_n <= 1'b0;
        end else begin
            cts_n <= !(next_state == ST_AWAKE || next_state == ST_PEND) ||
                (flow_pin_function == FP_CTS_FLOW &&
                uart_rx_full);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            routing_mode <= 1'b1;
        end else begin
            routing_mode <= sleep_mode_select == SM_OFF;
        end
    end
endmodule : edsc_top

// ==== rtl/edsc_pkg.sv ====
// Purpose: Shared constants and types of the end device sleep controller
// Assumes: 25 MHz pclk, 10 ms timer base
// Notes: Timer fields count in units of the 10 ms base tick
package edsc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POLL = 8'h04;
    localparam logic [7:0] ADDR_INACT = 8'h08;
    localparam logic [7:0] ADDR_MULT = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // Control field positions
    localparam int CTRL_SM_LSB = 0;
    localparam int CTRL_SO_LSB = 4;
    localparam int CTRL_FP_LSB = 8;
    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_AWAKE_BIT = 4;
    localparam int STAT_JOINED_BIT = 5;
    localparam int STAT_ROUTE_BIT = 6;
    localparam int STAT_WCNT_LSB = 16;

    // Mode encodings
    localparam logic [2:0] SM_OFF = 3'h0;
    localparam logic [2:0] SM_PIN = 3'h1;
    localparam logic [2:0] SM_CYC = 3'h4;
    localparam logic [2:0] SM_CYC_PIN = 3'h5;
    localparam logic [2:0] SO_NONE = 3'h0;
    localparam logic [2:0] SO_LONG = 3'h4;
    localparam logic [2:0] FP_CTS_FLOW = 3'h1;

    // Reset values
    localparam logic [11:0] POLL_RST = 12'h0c8;
    localparam logic [15:0] INACT_RST = 16'h01f4;
    localparam logic [15:0] MULT_RST = 16'h0001;

    // Timing
    localparam int CLK_NS = 40;
    localparam int TICK_NS = 10000000;
    localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_NS;
    localparam int TICK_MS = 10;
    localparam int POLL_INTERVAL_MS = 100;
    localparam int POLL_MAX_MS = 28000;
    localparam int BUTTON_MS = 30000;
    localparam logic [3:0] POLL_TICKS = 4'(POLL_INTERVAL_MS / TICK_MS);
    localparam logic [11:0] POLL_MAX = 12'(POLL_MAX_MS / TICK_MS);
    localparam logic [11:0] BUTTON_TICKS = 12'(BUTTON_MS / TICK_MS);

    typedef enum logic [3:0] {
        ST_AWAKE = 4'h1,
        ST_PEND = 4'h2,
        ST_ASLEEP = 4'h4,
        ST_SILENT = 4'h8
    } edsc_state_e;
endpackage : edsc_pkg

// ==== verif/edsc_sva.sv ====
// Purpose: Port-level temporal checks of the sleep controller
// Assumes: One pclk domain, async active-low reset
// Notes: Wake latencies get two cycles of slack
module edsc_sva
    import edsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic commission_button,
    input wire logic joined,
    input wire logic join_busy,
    input wire logic txrx_busy,
    input wire logic uart_rx_full,
    input wire logic awake_indicator,
    input wire logic cts_n,
    input wire logic routing_mode,
    input wire logic sleeping,
    input wire logic serial_rx_accept,
    input wire logic radio_rx_accept,
    input wire logic poll_req,
    input wire logic scan_start,
    input wire logic leave_rejoin
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    int unsigned gap;
    // Cycles since the last poll of a joined end device that stays awake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 0;
        end else if (poll_req || sleeping || !joined || routing_mode) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    a_route_no_sleep: assert property (routing_mode |-> !sleeping)
        else $error("router slept");
    a_leave_on_mode: assert property (psel && penable && pwrite &&
        paddr == ADDR_CTRL && pwdata[2:0] != SM_OFF && routing_mode
        |=> ##[0:1] leave_rejoin) else $error("no leave and rejoin");
    a_ind_level: assert property (awake_indicator != sleeping)
        else $error("indicator wrong");
    a_cts_asleep: assert property (sleeping |-> cts_n)
        else $error("cts low asleep");
    a_idle_first: assert property ($rose(sleeping) |->
        $past(txrx_busy) == 1'b0 && $past(join_busy) == 1'b0)
        else $error("slept while busy");
    a_rx_ignored: assert property (sleeping |-> !serial_rx_accept)
        else $error("serial taken asleep");
    a_wake_ready: assert property ($fell(sleeping) && !uart_rx_full
        |-> !cts_n) else $error("not ready on wake");
    a_wake_scan: assert property ($fell(sleeping) && !joined
        |-> ##[0:2] scan_start) else $error("no scan on wake");
    a_wake_poll: assert property ($fell(sleeping) && joined
        |-> ##[0:2] poll_req) else $error("no poll on wake");
    a_poll_gap: assert property (gap <= 10 * TICK_CYCLES + 3)
        else $error("poll gap too long");
    a_silent_rx: assert property (sleeping && radio_rx_accept
        |-> ##[1:2] awake_indicator) else $error("silent rx no wake");
    a_button_wake: assert property (commission_button
        |-> ##[1:2] !sleeping) else $error("button no wake");
endmodule : edsc_sva

// ==== verif/edsc_host.sv ====
// Purpose: Host processor model on the sleep request pin
// Assumes: Host logic runs from pclk
// Notes: Pin follows the bench request one cycle late, like a port flop
module edsc_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic want_sleep,
    input wire logic cts_n,
    output logic sleep_request_pin,
    output logic may_send
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_request_pin <= 1'b0;
        end else begin
            sleep_request_pin <= want_sleep;
        end
    end
    // Host only sends once the device shows ready
    assign may_send = !cts_n;
endmodule : edsc_host

// ==== verif/edsc_top_tb.sv ====
// Purpose: Self-checking bench of the sleep controller
// Assumes: Tick shortened to 4 pclk cycles
// Notes: Pulse monitors count events so tasks never miss one
module edsc_top_tb
    import edsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic want_sleep, sleep_request_pin, may_send, commission_button;
    logic joined, join_busy, txrx_busy, serial_rx_evt, radio_rx_evt;
    logic uart_rx_full, awake_indicator, cts_n, routing_mode, sleeping;
    logic serial_rx_accept, radio_rx_accept, poll_req, scan_start;
    logic leave_rejoin;
    int fail_count = 0, samples_checked = 0, waited, n_poll = 0;
    int n_scan = 0, n_lr = 0;
    wire logic [2:0] obs = {poll_req, awake_indicator, sleeping};
    edsc_top #(.TICK_CYCLES(TC)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sleep_request_pin, .commission_button, .joined, .join_busy,
        .txrx_busy, .serial_rx_evt, .radio_rx_evt, .uart_rx_full,
        .awake_indicator, .cts_n, .routing_mode, .sleeping,
        .serial_rx_accept, .radio_rx_accept, .poll_req, .scan_start,
        .leave_rejoin);
    edsc_host host (.pclk, .presetn, .want_sleep, .cts_n,
        .sleep_request_pin, .may_send);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        n_poll <= n_poll + int'(poll_req === 1'b1);
        n_scan <= n_scan + int'(scan_start === 1'b1);
        n_lr <= n_lr + int'(leave_rejoin === 1'b1);
    end
    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    // Held until pready is seen high, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat === e, "read data");
    endtask : rd
    task automatic wt(input int b, input logic v, input int lim);
        waited = 0;
        while (obs[b] !== v && waited < lim) begin
            @(posedge pclk);
            waited++;
        end
        chk(obs[b] === v, "wait expired");
    endtask : wt
    task automatic t_regs;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_POLL, 32'(POLL_RST));
        rd(ADDR_INACT, 32'(INACT_RST));
        rd(ADDR_MULT, 32'(MULT_RST));
        rd(ADDR_STAT, 32'h51);
        xfer(1'b1, ADDR_POLL, 32'hfff);
        rd(ADDR_POLL, 32'(POLL_MAX));
        xfer(1'b1, 8'h14, 32'h5);
        chk(rerr === 1'b1, "unmapped");
        $display("register test done");
    endtask : t_regs
    task automatic t_mode0;
        int n;
        want_sleep <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(sleeping === 1'b0 && routing_mode === 1'b1, "router");
        want_sleep <= 1'b0;
        n = n_lr;
        xfer(1'b1, ADDR_CTRL, {29'h0, SM_PIN});
        repeat (3) @(posedge pclk);
        chk(n_lr == n + 1 && routing_mode === 1'b0, "rejoin");
        $display("mode zero test done");
    endtask : t_mode0
    task automatic t_pin;
        int n;
        joined <= 1'b1;
        txrx_busy <= 1'b1;
        want_sleep <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(sleeping === 1'b0, "slept busy");
        txrx_busy <= 1'b0;
        wt(0, 1'b1, 5);
        chk(awake_indicator === 1'b0 && cts_n === 1'b1, "pins");
        serial_rx_evt <= 1'b1;
        radio_rx_evt <= 1'b1;
        @(posedge pclk);
        serial_rx_evt <= 1'b0;
        radio_rx_evt <= 1'b0;
        chk(serial_rx_accept === 1'b0 && radio_rx_accept === 1'b0, "rx");
        n = n_poll;
        want_sleep <= 1'b0;
        wt(0, 1'b0, 5);
        chk(cts_n === 1'b0 && may_send === 1'b1, "ready");
        repeat (3) @(posedge pclk);
        chk(n_poll == n + 1, "wake poll");
        wt(2, 1'b1, 10 * TC + 2);
        chk(waited > 8 * TC, "poll early");
        xfer(1'b1, ADDR_CTRL, {21'h0, FP_CTS_FLOW, 5'h0, SM_PIN});
        uart_rx_full <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(cts_n === 1'b1, "flow hold");
        uart_rx_full <= 1'b0;
        xfer(1'b1, ADDR_CTRL, {29'h0, SM_PIN});
        chk(cts_n === 1'b0, "flow release");
        $display("pin sleep test done");
    endtask : t_pin
    task automatic t_join;
        int n;
        // Short inactivity time, so the wake below reloads a short timer
        xfer(1'b1, ADDR_INACT, 32'h2);
        joined <= 1'b0;
        join_busy <= 1'b1;
        want_sleep <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(sleeping === 1'b0, "slept mid join");
        join_busy <= 1'b0;
        wt(0, 1'b1, 5);
        n = n_scan;
        want_sleep <= 1'b0;
        wt(0, 1'b0, 5);
        repeat (3) @(posedge pclk);
        chk(n_scan == n + 1, "scan");
        $display("join test done");
    endtask : t_join
    task automatic t_cyc(input logic [2:0] so);
        int n;
        joined <= 1'b1;
        xfer(1'b1, ADDR_POLL, 32'h2);
        xfer(1'b1, ADDR_MULT, 32'h3);
        xfer(1'b1, ADDR_INACT, 32'h2);
        xfer(1'b1, ADDR_CTRL, {25'h0, so, 1'b0, SM_CYC});
        wt(0, 1'b1, 30 * TC);
        n = n_poll;
        wt(1, 1'b1, 20 * TC);
        chk(n_poll - n == (so == SO_NONE ? 2 : 0), "polls");
        chk(waited >= 5 * TC && waited <= 7 * TC, "period");
        $display("cyclic test done");
    endtask : t_cyc
    task automatic t_rx;
        repeat (8) begin
            serial_rx_evt <= 1'b1;
            @(posedge pclk);
            serial_rx_evt <= 1'b0;
            chk(serial_rx_accept === 1'b1 && sleeping === 1'b0, "rx");
            repeat (TC) @(posedge pclk);
        end
        wt(0, 1'b1, 3 * TC);
        xfer(1'b1, ADDR_CTRL, {29'h0, SM_CYC});
        wt(0, 1'b1, 30 * TC);
        radio_rx_evt <= 1'b1;
        wt(1, 1'b1, 4 * TC);
        radio_rx_evt <= 1'b0;
        $display("activity test done");
    endtask : t_rx
    task automatic t_pinwake(input logic [2:0] sm, input logic stays);
        xfer(1'b1, ADDR_MULT, 32'h64);
        xfer(1'b1, ADDR_CTRL, {29'h0, sm});
        wt(0, 1'b1, 30 * TC);
        want_sleep <= 1'b1;
        repeat (3) @(posedge pclk);
        want_sleep <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(sleeping === stays, "pin wake");
        $display("pin wake test done");
    endtask : t_pinwake
    task automatic t_button;
        wt(0, 1'b1, 30 * TC);
        commission_button <= 1'b1;
        @(posedge pclk);
        commission_button <= 1'b0;
        wt(0, 1'b0, 3);
        repeat (10) begin
            repeat (20) @(posedge pclk);
            chk(sleeping === 1'b0, "button hold");
        end
        $display("button test done");
    endtask : t_button
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("BAD %0t watchdog", $time);
        conclude();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {want_sleep, commission_button, joined, join_busy} = '0;
        {txrx_busy, serial_rx_evt, radio_rx_evt, uart_rx_full} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_mode0();
        t_pin();
        t_join();
        t_cyc(SO_NONE);
        t_cyc(SO_LONG);
        t_rx();
        t_pinwake(SM_CYC, 1'b1);
        t_pinwake(SM_CYC_PIN, 1'b0);
        t_button();
        conclude();
    end
endmodule : edsc_top_tb
bind edsc_top edsc_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .commission_button, .joined,
    .join_busy, .txrx_busy, .uart_rx_full, .awake_indicator, .cts_n,
    .routing_mode, .sleeping, .serial_rx_accept, .radio_rx_accept,
    .poll_req, .scan_start, .leave_rejoin);
